/* rtl/ccg_cfg.svh */
// Offsets, field positions, reset values and counts of the clock control core
`ifndef CCG_CFG_SVH
`define CCG_CFG_SVH
`define CCG_NUM_BANKS 4
`define CCG_NUM_DIV 5
`define CCG_NUM_OUT 8
`define CCG_PROF_WORDS 8
`define CCG_MEM_AW 5
`define CCG_MEM_WORDS 32
`define CCG_ADDR_MEM_BASE 32'h0000_0000
`define CCG_ADDR_MEM_LAST 32'h0000_007C
`define CCG_ADDR_STATUS 32'h0000_0080
`define CCG_HSIZE_WORD 3'h2
`define CCG_HI_BANK_LSB 16
`define CCG_BANK_W 9
`define CCG_PRE_W 6
`define CCG_DIV_W 7
`define CCG_PRE_RESET 6'h01
`define CCG_DIV_RESET 7'h02
`define CCG_BANK_RESET 9'h000
`define CCG_PRE_MIN 6'h01
`define CCG_DIV_MIN 7'h02
`define CCG_DIV_SEL_MAX 3'h4
`define CCG_LOCK_GOOD 4'h8
`define CCG_LAST_IDX 3'h7
`define CCG_ST_LOCKED 0
`define CCG_ST_BUSY 1
`define CCG_ST_PROF_LSB 2
`define CCG_ST_RUN_LSB 4
`define CCG_ST_GATE 8
`endif

/* rtl/ccg_pkg.sv */
// Types shared by the clock control core
package ccg_pkg;
   typedef enum logic [1:0] {
      OE_ON = 2'h0, OE_OFF = 2'h1, OE_FIRST = 2'h2, OE_SECOND = 2'h3
   } ccg_oe_mode_t;
   typedef enum logic [1:0] {
      LD_IDLE = 2'h0, LD_RUN = 2'h1, LD_LAST = 2'h3
   } ccg_ld_state_t;
   typedef enum logic [1:0] {
      RG_NONE = 2'h0, RG_MEM = 2'h1, RG_STATUS = 2'h2
   } ccg_region_t;
   typedef struct packed {
      ccg_oe_mode_t oe_b;
      ccg_oe_mode_t oe_a;
      logic idle_lvl;
      logic gate_en;
      logic [2:0] div_sel;
   } ccg_bank_cfg_t;
   typedef struct packed {
      logic [5:0] pre_ratio;
      logic [4:0][6:0] div_ratio;
      ccg_bank_cfg_t [3:0] bank;
   } ccg_profile_t;
   typedef struct packed {
      logic valid;
      logic write;
      ccg_region_t region;
      logic [4:0] widx;
   } ccg_ahb_req_t;
endpackage

/* rtl/ccg_prof_mem.sv */
// Profile store: one write port, two registered read ports
`include "ccg_cfg.svh"
module ccg_prof_mem (
   // Clock
   input logic clk,
   // Write port
   input logic we,
   input logic [4:0] waddr,
   input logic [31:0] wdata,
   // Read ports
   input logic [4:0] ra_addr,
   output logic [31:0] ra_data,
   input logic [4:0] rb_addr,
   output logic [31:0] rb_data
);
   logic [31:0] mem [`CCG_MEM_WORDS];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Write-first so a read right behind a write sees the new word
   always_ff @(posedge clk) begin
      ra_data <= (we && waddr == ra_addr) ? wdata : mem[ra_addr];
      rb_data <= (we && waddr == rb_addr) ? wdata : mem[rb_addr];
   end
endmodule

/* rtl/ccg_clock_ctl.sv */
// Clock control core: profiles, dividers, sync gating, enables, lock flag
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`include "ccg_cfg.svh"
module ccg_clock_ctl
   import ccg_pkg::*;
(
   // Clock and reset
   input logic MCLK,
   input logic NRST,
   // AHB-Lite slave
   input logic HSEL,
   input logic [31:0] HADDR,
   input logic [1:0] HTRANS,
   input logic HWRITE,
   input logic [2:0] HSIZE,
   input logic [31:0] HWDATA,
   input logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Clock inputs and selects
   input logic REF_PAIR_A,
   input logic REF_PAIR_B,
   input logic REF_INPUT_SELECT,
   input logic FEEDBACK_PAIR_A,
   input logic FEEDBACK_PAIR_B,
   input logic FEEDBACK_INPUT_SELECT,
   // Control pins
   input logic SYNC_OUTPUT_GATE,
   input logic OUTPUT_ENABLE_FIRST,
   input logic OUTPUT_ENABLE_SECOND,
   input logic GLOBAL_TRISTATE_CTL,
   input logic PROFILE_SEL_BIT0,
   input logic PROFILE_SEL_BIT1,
   input logic LOOP_BYPASS,
   input logic LOOP_RESET,
   // Outputs
   output logic PLL_PHASE_ALIGNED_N,
   output logic [7:0] BANK_OUT,
   output logic [7:0] BANK_OE_N
);
   function automatic ccg_region_t ccg_decode(input logic [31:0] a);
      if (a <= `CCG_ADDR_MEM_LAST) begin
         return RG_MEM;
      end else if (a == `CCG_ADDR_STATUS) begin
         return RG_STATUS;
      end else begin
         return RG_NONE;
      end
   endfunction

   function automatic logic [6:0] ccg_div_next(input logic [6:0] cnt, input logic [6:0] r);
      logic [6:0] lim;
      lim = (r < `CCG_DIV_MIN) ? `CCG_DIV_MIN : r;
      return (cnt + 7'h01 >= lim) ? 7'h00 : cnt + 7'h01;
   endfunction

   function automatic logic [2:0] ccg_sel(input logic [2:0] s);
      return (s > `CCG_DIV_SEL_MAX) ? 3'h0 : s;
   endfunction

   function automatic logic ccg_oe_on(input ccg_oe_mode_t m, input logic f, input logic s);
      case (m)
         OE_ON: return 1'b1;
         OE_FIRST: return f;
         OE_SECOND: return s;
         default: return 1'b0;
      endcase
   endfunction

   logic [1:0] rst_sync_reg;
   logic rst_n;
   ccg_ahb_req_t req_reg;
   logic ahb_go;
   logic [31:0] status_reg;
   logic mem_we;
   logic [31:0] mem_a_data, mem_b_data;
   ccg_ld_state_t ld_state_reg;
   logic [2:0] ld_idx_reg, cap_idx_reg;
   logic cap_vld_reg, reload_reg, wr_active;
   logic [1:0] prof_reg, prof_pin;
   ccg_profile_t cfg_reg;
   logic ref_lvl, fb_lvl, ref_prev_reg, fb_prev_reg, ref_rise, fb_rise;
   logic [5:0] pre_cnt_reg;
   logic pre_pulse_reg, div_tick;
   logic [6:0] div_cnt_reg [`CCG_NUM_DIV];
   logic [4:0] div_clk_reg;
   logic sg_meta_reg, sg_sync_reg;
   logic [3:0] run_reg, bank_out_reg, bank_clk;
   logic [7:0] oe_n_reg;
   logic seen_reg, aligned_n_reg;
   logic [3:0] good_reg;

   // Reset release through two flops
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // Bus slave: zero wait states, always OKAY
   assign ahb_go = HSEL && HTRANS[1] && HREADY && HSIZE == `CCG_HSIZE_WORD;
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         req_reg <= '0;
         status_reg <= 32'h0000_0000;
      end else if (HREADY) begin
         req_reg <= '{valid: ahb_go, write: HWRITE, region: ccg_decode(HADDR),
                      widx: HADDR[6:2]};
         status_reg <= 32'h0000_0000;
         status_reg[`CCG_ST_LOCKED] <= !aligned_n_reg;
         status_reg[`CCG_ST_BUSY] <= ld_state_reg != LD_IDLE;
         status_reg[`CCG_ST_PROF_LSB +: 2] <= prof_reg;
         status_reg[`CCG_ST_RUN_LSB +: 4] <= run_reg;
         status_reg[`CCG_ST_GATE] <= sg_sync_reg;
      end
   end
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign mem_we = req_reg.valid && req_reg.write && req_reg.region == RG_MEM;
   always_comb begin
      HRDATA = 32'h0000_0000;
      if (req_reg.valid && !req_reg.write && req_reg.region == RG_MEM) begin
         HRDATA = mem_a_data;
      end else if (req_reg.valid && !req_reg.write && req_reg.region == RG_STATUS) begin
         HRDATA = status_reg;
      end
   end

   ccg_prof_mem u_mem (
      .clk(MCLK),
      .we(mem_we),
      .waddr(req_reg.widx),
      .wdata(HWDATA),
      .ra_addr(HADDR[6:2]),
      .ra_data(mem_a_data),
      .rb_addr({prof_reg, ld_idx_reg}),
      .rb_data(mem_b_data)
   );

   // Profile loader walks the eight words of the chosen profile
   assign prof_pin = {PROFILE_SEL_BIT1, PROFILE_SEL_BIT0};
   assign wr_active = mem_we && req_reg.widx[4:3] == prof_reg;
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         ld_state_reg <= LD_IDLE;
         ld_idx_reg <= 3'h0;
         prof_reg <= 2'h0;
         reload_reg <= 1'b0;
      end else begin
         case (ld_state_reg)
            LD_IDLE: begin
               if (prof_pin != prof_reg || reload_reg || wr_active) begin
                  prof_reg <= prof_pin;
                  ld_idx_reg <= 3'h0;
                  reload_reg <= 1'b0;
                  ld_state_reg <= LD_RUN;
               end
            end
            LD_RUN: begin
               reload_reg <= reload_reg | wr_active;
               ld_idx_reg <= ld_idx_reg + 3'h1;
               if (ld_idx_reg == `CCG_LAST_IDX) begin
                  ld_state_reg <= LD_LAST;
               end
            end
            default: begin
               reload_reg <= reload_reg | wr_active;
               ld_state_reg <= LD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         cap_vld_reg <= 1'b0;
         cap_idx_reg <= 3'h0;
         cfg_reg.pre_ratio <= `CCG_PRE_RESET;
         cfg_reg.div_ratio <= {`CCG_NUM_DIV{`CCG_DIV_RESET}};
         cfg_reg.bank <= {`CCG_NUM_BANKS{`CCG_BANK_RESET}};
      end else begin
         cap_vld_reg <= ld_state_reg == LD_RUN;
         cap_idx_reg <= ld_idx_reg;
         if (cap_vld_reg) begin
            case (cap_idx_reg)
               3'h0: cfg_reg.pre_ratio <= mem_b_data[`CCG_PRE_W-1:0];
               3'h6: begin
                  cfg_reg.bank[0] <= mem_b_data[`CCG_BANK_W-1:0];
                  cfg_reg.bank[1] <= mem_b_data[`CCG_HI_BANK_LSB +: `CCG_BANK_W];
               end
               3'h7: begin
                  cfg_reg.bank[2] <= mem_b_data[`CCG_BANK_W-1:0];
                  cfg_reg.bank[3] <= mem_b_data[`CCG_HI_BANK_LSB +: `CCG_BANK_W];
               end
               default: cfg_reg.div_ratio[cap_idx_reg - 3'h1] <= mem_b_data[`CCG_DIV_W-1:0];
            endcase
         end
      end
   end

   // Input selection and pre-divider
   assign ref_lvl = REF_INPUT_SELECT ? REF_PAIR_B : REF_PAIR_A;
   // Feedback buffer is off while outputs are floated
   assign fb_lvl = (FEEDBACK_INPUT_SELECT ? FEEDBACK_PAIR_B : FEEDBACK_PAIR_A)
                   && !GLOBAL_TRISTATE_CTL;
   assign ref_rise = ref_lvl && !ref_prev_reg;
   assign fb_rise = fb_lvl && !fb_prev_reg;
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         ref_prev_reg <= 1'b0;
         fb_prev_reg <= 1'b0;
      end else begin
         ref_prev_reg <= ref_lvl;
         fb_prev_reg <= fb_lvl;
      end
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_reg <= 6'h00;
         pre_pulse_reg <= 1'b0;
      end else if (LOOP_RESET) begin
         pre_cnt_reg <= 6'h00;
         pre_pulse_reg <= 1'b0;
      end else begin
         pre_pulse_reg <= 1'b0;
         if (ref_rise) begin
            if (pre_cnt_reg + 6'h01 >= cfg_reg.pre_ratio) begin
               pre_cnt_reg <= 6'h00;
               pre_pulse_reg <= 1'b1;
            end else begin
               pre_cnt_reg <= pre_cnt_reg + 6'h01;
            end
         end
      end
   end

   // Oscillator stands in as one tick per cycle; bypass takes the pre-divider
   assign div_tick = LOOP_BYPASS ? pre_pulse_reg : 1'b1;

   for (genvar d = 0; d < `CCG_NUM_DIV; d++) begin : g_div
      logic [6:0] nxt;
      assign nxt = ccg_div_next(div_cnt_reg[d], cfg_reg.div_ratio[d]);
      always_ff @(posedge MCLK or negedge rst_n) begin
         if (!rst_n) begin
            div_cnt_reg[d] <= 7'h00;
            div_clk_reg[d] <= 1'b0;
         end else if (LOOP_RESET) begin
            div_cnt_reg[d] <= 7'h00;
            div_clk_reg[d] <= 1'b0;
         end else if (div_tick) begin
            div_cnt_reg[d] <= nxt;
            div_clk_reg[d] <= nxt < (cfg_reg.div_ratio[d] >> 1);
         end
      end
   end

   // Gate synchroniser
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         sg_meta_reg <= 1'b0;
         sg_sync_reg <= 1'b0;
      end else begin
         sg_meta_reg <= SYNC_OUTPUT_GATE;
         sg_sync_reg <= sg_meta_reg;
      end
   end

   for (genvar b = 0; b < `CCG_NUM_BANKS; b++) begin : g_bank
      ccg_bank_cfg_t bc;
      assign bc = cfg_reg.bank[b];
      assign bank_clk[b] = div_clk_reg[ccg_sel(bc.div_sel)];
      always_ff @(posedge MCLK or negedge rst_n) begin
         if (!rst_n) begin
            run_reg[b] <= 1'b1;
            bank_out_reg[b] <= 1'b0;
         end else begin
            if (!bc.gate_en) begin
               run_reg[b] <= 1'b1;
            end else if (bank_clk[b] == bc.idle_lvl) begin
               // Only at idle level, so neither edge of the gate cuts a pulse
               run_reg[b] <= sg_sync_reg;
            end
            bank_out_reg[b] <= run_reg[b] ? bank_clk[b] : bc.idle_lvl;
         end
      end
      for (genvar k = 0; k < 2; k++) begin : g_oe
         ccg_oe_mode_t m;
         assign m = k ? bc.oe_b : bc.oe_a;
         always_ff @(posedge MCLK or negedge rst_n) begin
            if (!rst_n) begin
               oe_n_reg[2*b+k] <= 1'b1;
            end else begin
               oe_n_reg[2*b+k] <= GLOBAL_TRISTATE_CTL
                  || !ccg_oe_on(m, OUTPUT_ENABLE_FIRST, OUTPUT_ENABLE_SECOND);
            end
         end
         assign BANK_OUT[2*b+k] = bank_out_reg[b];
      end
   end
   assign BANK_OE_N = oe_n_reg;

   // Lock: every reference edge must see a feedback edge since the previous one
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         seen_reg <= 1'b0;
         good_reg <= 4'h0;
         aligned_n_reg <= 1'b1;
      end else if (LOOP_RESET || GLOBAL_TRISTATE_CTL) begin
         seen_reg <= 1'b0;
         good_reg <= 4'h0;
         aligned_n_reg <= 1'b1;
      end else begin
         if (ref_rise) begin
            seen_reg <= fb_rise;
            if (!(seen_reg || fb_rise)) begin
               good_reg <= 4'h0;
            end else if (good_reg != `CCG_LOCK_GOOD) begin
               good_reg <= good_reg + 4'h1;
            end
         end else if (fb_rise) begin
            seen_reg <= 1'b1;
         end
         aligned_n_reg <= good_reg != `CCG_LOCK_GOOD;
      end
   end
   assign PLL_PHASE_ALIGNED_N = aligned_n_reg;

   default clocking @(posedge MCLK); endclocking
   default disable iff (!rst_n);

   sequence seq_prof_change;
      ld_state_reg == LD_IDLE && prof_pin != prof_reg;
   endsequence
   sequence seq_load_walk;
      (ld_state_reg != LD_IDLE)[*8] ##1 ld_state_reg == LD_LAST ##1 ld_state_reg == LD_IDLE;
   endsequence

   a_ref_pick_a: assert property ((!REF_INPUT_SELECT && REF_PAIR_A && !ref_prev_reg
      && !LOOP_RESET) |=> (pre_pulse_reg || pre_cnt_reg != $past(pre_cnt_reg)))
      else $error("reference edge on pair A not counted");
   a_fb_pick_b: assert property ((FEEDBACK_INPUT_SELECT && FEEDBACK_PAIR_B && !fb_prev_reg
      && !ref_rise && !LOOP_RESET && !GLOBAL_TRISTATE_CTL) |=> seen_reg)
      else $error("feedback edge on pair B not seen");
   a_lock_flag_low: assert property ((good_reg == `CCG_LOCK_GOOD && !LOOP_RESET
      && !GLOBAL_TRISTATE_CTL) |=> !PLL_PHASE_ALIGNED_N)
      else $error("lock flag not low when locked");
   a_gate_off_follow: assert property ((!cfg_reg.bank[0].gate_en ##1
      !cfg_reg.bank[0].gate_en) |-> BANK_OUT[0] == $past(div_clk_reg[ccg_sel(
      cfg_reg.bank[0].div_sel)]))
      else $error("ungated bank does not follow its divider");
   a_gate_pass_clk: assert property ((cfg_reg.bank[0].gate_en && run_reg[0]) |=>
      BANK_OUT[0] == $past(bank_clk[0]))
      else $error("running gated bank does not pass clock");
   a_gate_hold_lvl: assert property ((cfg_reg.bank[0].gate_en && !run_reg[0]) |=>
      BANK_OUT[0] == $past(cfg_reg.bank[0].idle_lvl))
      else $error("stopped bank not at idle level");
   a_gate_edge_idle: assert property ((cfg_reg.bank[0].gate_en
      && bank_clk[0] != cfg_reg.bank[0].idle_lvl) |=> $stable(run_reg[0]))
      else $error("gate changed away from idle level");
   a_oe_mode_off: assert property ((cfg_reg.bank[0].oe_a == OE_OFF) |=> BANK_OE_N[0])
      else $error("output off mode still drives");
   a_global_float: assert property (GLOBAL_TRISTATE_CTL |=> BANK_OE_N == 8'hFF)
      else $error("global tristate left an output driven");
   a_global_unlock: assert property (GLOBAL_TRISTATE_CTL |=>
      (PLL_PHASE_ALIGNED_N && good_reg == 4'h0))
      else $error("lock kept while feedback cut");
   a_prof_load: assert property (seq_prof_change |=> seq_load_walk)
      else $error("profile change did not load eight words");
   a_osc_drive: assert property ((!LOOP_BYPASS && !LOOP_RESET) |=>
      div_cnt_reg[0] != $past(div_cnt_reg[0]))
      else $error("divider idle with oscillator source");
   a_bypass_drive: assert property ((LOOP_BYPASS && !pre_pulse_reg && !LOOP_RESET) |=>
      $stable(div_cnt_reg[0]))
      else $error("divider moved without pre-divider pulse");
   a_reset_clear: assert property (LOOP_RESET |=> (PLL_PHASE_ALIGNED_N
      && pre_cnt_reg == 6'h00 && div_cnt_reg[4] == 7'h00))
      else $error("loop reset did not clear counters");
endmodule

/* dv/ccg_board_model.sv */
// Board-side clock sources feeding the reference and feedback pairs
module ccg_board_model #(
   parameter int HALF = 8
) (
   // Clock
   input wire logic clk,
   // Source enables: ref A, ref B, feedback A, feedback B
   input wire logic [3:0] en,
   // Clock pins
   output logic ref_a,
   output logic ref_b,
   output logic fb_a,
   output logic fb_b
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   logic ck = 1'b0;
   // Feedback edges line up with reference edges, as a settled loop returns them
   always_ff @(posedge clk) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) ck <= ~ck;
   end
   // Unused pairs are grounded on the board, so a disabled source sits low
   assign ref_a = ck & en[0];
   assign ref_b = ck & en[1];
   assign fb_a = ck & en[2];
   assign fb_b = ck & en[3];
endmodule

/* dv/tb.sv */
// Self-checking bench for the clock control core
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK = 0, NRST = 0, HSEL = 0, HWRITE = 0, REF_INPUT_SELECT = 0;
   logic FEEDBACK_INPUT_SELECT = 0, SYNC_OUTPUT_GATE = 1, OUTPUT_ENABLE_FIRST = 1;
   logic OUTPUT_ENABLE_SECOND = 0, GLOBAL_TRISTATE_CTL = 0, PROFILE_SEL_BIT0 = 0;
   logic PROFILE_SEL_BIT1 = 0, LOOP_BYPASS = 0, LOOP_RESET = 0, mon = 0;
   logic [1:0] HTRANS = 2'h0;
   logic [2:0] HSIZE = 3'h2;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd_hold, q;
   logic HREADYOUT, HRESP, PLL_PHASE_ALIGNED_N;
   logic REF_PAIR_A, REF_PAIR_B, FEEDBACK_PAIR_A, FEEDBACK_PAIR_B;
   logic [7:0] BANK_OUT, BANK_OE_N;
   logic [3:0] src_en = 4'h6;
   logic [31:0] w [8];
   int n_errors = 0, total_checks = 0, run = 0;

   ccg_board_model i_ccg_board_model (.clk(MCLK), .en(src_en), .ref_a(REF_PAIR_A),
      .ref_b(REF_PAIR_B), .fb_a(FEEDBACK_PAIR_A), .fb_b(FEEDBACK_PAIR_B));
   ccg_clock_ctl i_ccg_clock_ctl (.MCLK(MCLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .REF_PAIR_A(REF_PAIR_A),
      .REF_PAIR_B(REF_PAIR_B), .REF_INPUT_SELECT(REF_INPUT_SELECT),
      .FEEDBACK_PAIR_A(FEEDBACK_PAIR_A), .FEEDBACK_PAIR_B(FEEDBACK_PAIR_B),
      .FEEDBACK_INPUT_SELECT(FEEDBACK_INPUT_SELECT), .SYNC_OUTPUT_GATE(SYNC_OUTPUT_GATE),
      .OUTPUT_ENABLE_FIRST(OUTPUT_ENABLE_FIRST), .OUTPUT_ENABLE_SECOND(OUTPUT_ENABLE_SECOND),
      .GLOBAL_TRISTATE_CTL(GLOBAL_TRISTATE_CTL), .PROFILE_SEL_BIT0(PROFILE_SEL_BIT0),
      .PROFILE_SEL_BIT1(PROFILE_SEL_BIT1), .LOOP_BYPASS(LOOP_BYPASS), .LOOP_RESET(LOOP_RESET),
      .PLL_PHASE_ALIGNED_N(PLL_PHASE_ALIGNED_N), .BANK_OUT(BANK_OUT), .BANK_OE_N(BANK_OE_N));

   initial begin
      forever #20 MCLK = ~MCLK;
   end
   // Read data as it stands at each rising edge; the master picks it up just after
   always @(posedge MCLK) rd_hold <= HRDATA;
   // Every high pulse of a gated divide-by-six bank must be whole
   always @(negedge MCLK) begin
      if (mon && BANK_OUT[0] === 1'b1) run++;
      else begin
         if (mon && run != 0) chk("gated pulse width", 3, run);
         run = 0;
      end
   end

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge MCLK);
   endtask
   task automatic wait_rdy();
      int k;
      k = 0;
      @(posedge MCLK);
      while (HREADYOUT !== 1'b1) begin
         k++;
         if (k > 50) begin
            n_errors++;
            final_report();
         end
         @(posedge MCLK);
      end
   endtask
   task automatic ahb(logic wr, logic [31:0] a, logic [31:0] d, output logic [31:0] r);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= a;
      HWRITE <= wr;
      wait_rdy();
      HTRANS <= 2'h0;
      HSEL <= 1'b0;
      HWDATA <= d;
      wait_rdy();
      #1 r = rd_hold;
      chk("bus response", 0, HRESP);
   endtask
   task automatic wait_flag(logic v, int lim, string nm);
      int k;
      k = 0;
      @(negedge MCLK);
      while (PLL_PHASE_ALIGNED_N !== v && k < lim) begin
         @(negedge MCLK);
         k++;
      end
      chk(nm, v, PLL_PHASE_ALIGNED_N);
      @(posedge MCLK);
   endtask
   task automatic lvl(string nm, int b, logic v);
      @(negedge MCLK);
      chk(nm, v, BANK_OUT[b]);
      @(posedge MCLK);
   endtask
   task automatic rng(string nm, int b, int n, int lo, int hi);
      int c;
      logic last;
      c = 0;
      @(negedge MCLK);
      last = BANK_OUT[b];
      repeat (n) begin
         @(negedge MCLK);
         if (BANK_OUT[b] !== last) c++;
         last = BANK_OUT[b];
      end
      total_checks++;
      if (c < lo || c > hi) begin
         n_errors++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, c);
      end
      @(posedge MCLK);
   endtask

   initial begin
      cyc(8);
      NRST <= 1'b1;
      cyc(4);
      chk("enables after reset", 8'h00, BANK_OE_N);
      chk("flag after reset", 1, PLL_PHASE_ALIGNED_N);
      // Reference A is dead, B carries the clock
      cyc(200);
      wait_flag(1'b1, 0, "no lock on dead pair");
      REF_INPUT_SELECT <= 1'b1;
      wait_flag(1'b0, 400, "lock on pair b");
      FEEDBACK_INPUT_SELECT <= 1'b1;
      wait_flag(1'b1, 60, "lock lost on dead feedback");
      FEEDBACK_INPUT_SELECT <= 1'b0;
      wait_flag(1'b0, 400, "relock feedback a");
      GLOBAL_TRISTATE_CTL <= 1'b1;
      cyc(3);
      chk("global float", 8'hFF, BANK_OE_N);
      wait_flag(1'b1, 0, "lock lost on float");
      GLOBAL_TRISTATE_CTL <= 1'b0;
      wait_flag(1'b0, 400, "relock after float");
      // Swap to ref A and feedback B, the only live pairs, under loop reset
      LOOP_RESET <= 1'b1;
      src_en <= 4'h9;
      REF_INPUT_SELECT <= 1'b0;
      FEEDBACK_INPUT_SELECT <= 1'b1;
      cyc(3);
      wait_flag(1'b1, 0, "loop reset drops lock");
      LOOP_RESET <= 1'b0;
      wait_flag(1'b0, 400, "relock on ref a and feedback b");
      $display("Test lock done");
      // Profile 3: divider 1 divides by six; bank0 gated idle 0; bank2 gated idle 1
      w = '{32'h1, 32'h2, 32'h6, 32'h2, 32'h2, 32'h2, 32'h129, 32'h18};
      for (int i = 0; i < 8; i++) ahb(1'b1, 32'h60 + 4 * i, w[i], q);
      ahb(1'b1, 32'h100, 32'hFFFF_FFFF, q);
      PROFILE_SEL_BIT0 <= 1'b1;
      PROFILE_SEL_BIT1 <= 1'b1;
      cyc(14);
      ahb(1'b0, 32'h80, 32'h0, q);
      chk("active profile", 3, (q >> 2) & 32'h3);
      // A byte-sized write must be ignored
      HSIZE <= 3'h0;
      ahb(1'b1, 32'h68, 32'h0, q);
      HSIZE <= 3'h2;
      ahb(1'b0, 32'h68, 32'h0, q);
      chk("profile word readback", 6, q);
      ahb(1'b0, 32'h100, 32'h0, q);
      chk("unmapped read", 0, q);
      for (int m = 0; m < 4; m++) begin
         ahb(1'b1, 32'h78, 32'h109 + 32 * m, q);
         cyc(13);
         chk("output a enable mode", (m == 1 || m == 3), BANK_OE_N[0]);
      end
      OUTPUT_ENABLE_SECOND <= 1'b1;
      cyc(3);
      chk("second enable drives", 0, BANK_OE_N[0]);
      OUTPUT_ENABLE_FIRST <= 1'b0;
      cyc(3);
      chk("first enable floats", 1, BANK_OE_N[1]);
      OUTPUT_ENABLE_FIRST <= 1'b1;
      $display("Test profile done");
      rng("bank0 runs on divider 1", 0, 30, 9, 11);
      rng("bank1 every oscillator tick", 2, 40, 38, 40);
      SYNC_OUTPUT_GATE <= 1'b0;
      cyc(10);
      lvl("bank0 held low", 0, 1'b0);
      lvl("bank2 held high", 4, 1'b1);
      rng("bank0 frozen", 0, 30, 0, 0);
      rng("ungated bank1 runs", 2, 30, 28, 30);
      mon <= 1'b1;
      repeat (10) begin
         SYNC_OUTPUT_GATE <= ~SYNC_OUTPUT_GATE;
         cyc(7);
      end
      cyc(10);
      mon <= 1'b0;
      $display("Test gating done");
      LOOP_BYPASS <= 1'b1;
      cyc(4);
      rng("bank1 on pre-divider pulses", 2, 64, 3, 5);
      $display("Test bypass done");
      final_report();
   end
endmodule
